// >>> rtl/hdlc_evq_pkg.sv
// Notes on behaviour
// - crc_corrupt_flag set means the frame ends with a deliberately corrupted CRC.
// - With CSMA/CR, csma_priority_select 1 gives class 8, 0 gives class 10.
// - frame_sent_ok in descriptor status is 1 on good transmission, else 0.
// - tx_abort_flag is 1 when software aborted the frame mid-transmission, else 0.
// - tx_underrun_flag is 1 when the transmit FIFO starved, else 0.
// - Buffer up to 2048 words; last word at base+count-1 odd, -2 even.
// - Event word: new status bit15, direction bit13, channel 12:8, zeros 7:5.
// - Read new_status_flag first; if 0 write the event with the flag set.
// - Flag already 1: leave location alone, set queue_overrun_flag, raise interrupt.
// - Direction 1 is transmit, 0 receive; channel index 0 to 31.
// - Transmit bit0 is repeat_ready_flag: waiting start or continue after abort.
// - queue_end_flag reported when DMA meets an end-of-queue descriptor.
// - Transmit halt bit set when DMA accepted halt; it waits for continue.
// - buffer_empty_flag reported when buffer emptied and buffer_irq_enable is 1.
// - frame_sent_ok reported only with buffer_irq_enable, on the last descriptor.
// - Receive bit0 is rx_frame_error: bad CRC, abort or FIFO overflow.
// - Receive halt bit set on accepted halt or abort outside a frame.
// - buffer_filled_flag reported when buffer filled and rx_buffer_irq_enable is 1.
// - frame_received_ok reported when frame ends with good CRC, last descriptor.
// - C/I word: flag bit15, port, 3-bit channel, primitive 5:0, after two matches.
// - port_select 0 is first GCI port, 1 second; each owns channels 0 to 7.
// - With timestamp_enable the C/I event adds a second word of counter value.
// - With buffer_irq_enable, report on frame sent if end of frame, else empty.
package hdlc_evq_pkg;
    localparam logic [7:0]  REG_GCFG    = 8'h00;
    localparam logic [7:0]  REG_QSIZE   = 8'h04;
    localparam logic [7:0]  REG_HQBASE  = 8'h08;
    localparam logic [7:0]  REG_CQBASE  = 8'h0C;
    localparam logic [7:0]  REG_INTSUM  = 8'h10;
    localparam logic [7:0]  REG_STATUS  = 8'h14;
    localparam logic [31:0] RST_WORD    = 32'h0000_0000;
    localparam logic [7:0]  QSIZE_RST   = 8'h10;
    localparam int          NS_BIT      = 15;
    localparam int          DIR_BIT     = 13;
    localparam int          CH_LSB      = 8;
    localparam int          PORT_BIT    = 11;
    localparam int          OK_BIT      = 4;
    localparam int          BUF_BIT     = 3;
    localparam int          HALT_BIT    = 2;
    localparam int          EOQ_BIT     = 1;
    localparam int          CRC_BIT     = 9;
    localparam int          PRI_BIT     = 8;
    localparam int          MAX_BUF_WORDS = 2048;
    localparam logic [12:0] MAX_BYTES   = 13'h1000;
    localparam logic [3:0]  PRIO_HI     = 4'h8;
    localparam logic [3:0]  PRIO_LO     = 4'hA;
    localparam logic [23:0] WORD_BYTES  = 24'h00_0002;
    localparam logic [23:0] DSTAT_OFS   = 24'h00_000A;

    typedef struct packed {
        logic       tx;
        logic [4:0] chan;
        logic       frame_ok;
        logic       irq_en;
        logic       eof;
        logic       buf_done;
        logic       halt;
        logic       queue_end_flag;
        logic       flag0;
    } hdlc_evt_t;

    typedef struct packed {
        logic       port;
        logic [2:0] chan;
        logic [5:0] prim;
    } ci_evt_t;

    typedef struct packed {
        logic [23:0] addr;
        logic        sent_ok;
        logic        abort;
        logic        underrun;
    } txd_stat_t;

    typedef struct packed {
        logic [23:0] base;
        logic [12:0] count;
        logic [15:0] word1;
    } txd_cfg_t;
endpackage : hdlc_evq_pkg

// >>> rtl/hdlc_event_queue_writer.sv
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module hdlc_event_queue_writer
    import hdlc_evq_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        MCLK,
    input  wire logic        RST,
    input  wire logic        CE,
    // Register port
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    output logic             IRQ,
    // HDLC frame events
    input  wire logic        HEV_VALID,
    input  wire hdlc_evt_t   HEV,
    output logic             HEV_BUSY,
    // Command/indicate samples
    input  wire logic        CI_VALID,
    input  wire ci_evt_t     CI,
    // Transmit descriptor status
    input  wire logic        TXS_VALID,
    input  wire txd_stat_t   TXS,
    output logic             TXS_BUSY,
    // Transmit descriptor decode
    input  wire logic        TXC_VALID,
    input  wire txd_cfg_t    TXC,
    output logic             TX_CRC_CORRUPT,
    output logic      [3:0]  TX_PRIO_CLASS,
    output logic      [23:0] TX_LAST_ADDR,
    output logic             TX_LEN_ERR,
    // Shared memory
    output logic             MEM_REQ,
    output logic             MEM_WE,
    output logic      [23:0] MEM_ADDR,
    output logic      [15:0] MEM_WDATA,
    input  wire logic        MEM_ACK,
    input  wire logic [15:0] MEM_RDATA
);
    typedef enum logic [2:0] {S_IDLE, S_READ, S_WR0, S_WR1, S_DESC} state_t;

    state_t      state_reg;
    logic        ts_en_reg;
    logic [15:0] qsize_reg;
    logic [23:0] hq_base_reg;
    logic [23:0] cq_base_reg;
    logic        ovr_reg;
    logic [7:0]  hq_ptr_reg;
    logic [7:0]  cq_ptr_reg;
    logic        h_pend_reg;
    logic [15:0] h_word_reg;
    logic        c_pend_reg;
    logic [15:0] c_word_reg;
    logic [15:0] c_ts_reg;
    logic        d_pend_reg;
    logic [23:0] d_addr_reg;
    logic [15:0] d_word_reg;
    logic        sel_ci_reg;
    logic [15:0] ts_cnt_reg;
    logic [5:0]  ci_last [16];
    logic [5:0]  ci_rep [16];
    logic [3:0]  ci_idx;
    logic        ci_new;
    logic        ovr_set;
    logic [7:0]  hq_ptr_next;
    logic [7:0]  cq_ptr_next;
    logic [8:0]  c_step;
    logic [8:0]  h_step;
    logic [12:0] x_ofs;

    assign ovr_set = (state_reg == S_READ) && MEM_ACK && MEM_RDATA[NS_BIT];

    // Registers written by software
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            ts_en_reg   <= 1'b0;
            qsize_reg   <= {QSIZE_RST, QSIZE_RST};
            hq_base_reg <= RST_WORD[23:0];
            cq_base_reg <= RST_WORD[23:0];
        end else if (CE && WR) begin
            unique case (ADDR)
                REG_GCFG:   ts_en_reg   <= WDATA[0];
                REG_QSIZE:  qsize_reg   <= WDATA[15:0];
                REG_HQBASE: hq_base_reg <= {WDATA[23:1], 1'b0};
                REG_CQBASE: cq_base_reg <= {WDATA[23:1], 1'b0};
                default: ;
            endcase
        end
    end

    // Overrun flag: write one clears, a new overrun wins
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            ovr_reg <= 1'b0;
            IRQ     <= 1'b0;
        end else if (CE) begin
            if (ovr_set) begin
                ovr_reg <= 1'b1;
            end else if (WR && ADDR == REG_INTSUM && WDATA[0]) begin
                ovr_reg <= 1'b0;
            end
            IRQ <= ovr_reg;
        end
    end

    // Read port, data valid one cycle after the strobe
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            RDATA <= RST_WORD;
        end else if (CE) begin
            RDATA <= RST_WORD;
            if (RD) begin
                unique case (ADDR)
                    REG_GCFG:   RDATA <= {31'h0000_0000, ts_en_reg};
                    REG_QSIZE:  RDATA <= {16'h0000, qsize_reg};
                    REG_HQBASE: RDATA <= {8'h00, hq_base_reg};
                    REG_CQBASE: RDATA <= {8'h00, cq_base_reg};
                    REG_INTSUM: RDATA <= {31'h0000_0000, ovr_reg};
                    REG_STATUS: RDATA <= {8'h00, cq_ptr_reg, hq_ptr_reg, 5'h00,
                                          d_pend_reg, c_pend_reg, h_pend_reg};
                    default: ;
                endcase
            end
        end
    end

    // Free-running time stamp counter
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            ts_cnt_reg <= 16'h0000;
        end else if (CE) begin
            ts_cnt_reg <= ts_cnt_reg + 16'h0001;
        end
    end

    // Transmit descriptor decode
    always_comb begin
        x_ofs = 13'h0000;
        if (TXC.count != 13'h0000) begin
            x_ofs = TXC.count[0] ? TXC.count - 13'h0001 : TXC.count - 13'h0002;
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            TX_CRC_CORRUPT <= 1'b0;
            TX_PRIO_CLASS  <= PRIO_LO;
            TX_LAST_ADDR   <= RST_WORD[23:0];
            TX_LEN_ERR     <= 1'b0;
        end else if (CE && TXC_VALID) begin
            TX_CRC_CORRUPT <= TXC.word1[CRC_BIT];
            TX_PRIO_CLASS  <= TXC.word1[PRI_BIT] ? PRIO_HI : PRIO_LO;
            TX_LAST_ADDR   <= TXC.base + {11'h000, x_ofs};
            TX_LEN_ERR     <= TXC.count > MAX_BYTES;
        end
    end

    // Command/indicate: report a primitive only after two equal samples
    assign ci_idx = {CI.port, CI.chan};
    assign ci_new = CI_VALID && CI.prim == ci_last[ci_idx] && CI.prim != ci_rep[ci_idx]
                    && !c_pend_reg;

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < 16; i++) begin
                ci_last[i] <= 6'h00;
                ci_rep[i]  <= 6'h00;
            end
        end else if (CE && CI_VALID) begin
            ci_last[ci_idx] <= CI.prim;
            if (ci_new) begin
                ci_rep[ci_idx] <= CI.prim;
            end
        end
    end

    // Pending events and their prebuilt words
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            h_pend_reg <= 1'b0;
            h_word_reg <= 16'h0000;
            c_pend_reg <= 1'b0;
            c_word_reg <= 16'h0000;
            c_ts_reg   <= 16'h0000;
            d_pend_reg <= 1'b0;
            d_addr_reg <= RST_WORD[23:0];
            d_word_reg <= 16'h0000;
        end else if (CE) begin
            if (HEV_VALID && !h_pend_reg) begin
                h_pend_reg                   <= 1'b1;
                h_word_reg                   <= 16'h0000;
                h_word_reg[NS_BIT]           <= 1'b1;
                h_word_reg[DIR_BIT]          <= HEV.tx;
                h_word_reg[CH_LSB+4:CH_LSB]  <= HEV.chan;
                h_word_reg[OK_BIT]           <= HEV.tx ? HEV.frame_ok && HEV.irq_en
                                                && HEV.eof : HEV.frame_ok;
                h_word_reg[BUF_BIT]          <= HEV.buf_done && HEV.irq_en
                                                && !(HEV.tx && HEV.eof);
                h_word_reg[HALT_BIT]         <= HEV.halt;
                h_word_reg[EOQ_BIT]          <= HEV.queue_end_flag;
                h_word_reg[0]                <= HEV.flag0;
            end else if (state_reg inside {S_READ, S_WR0} && MEM_ACK && !sel_ci_reg
                         && (ovr_set || state_reg == S_WR0)) begin
                h_pend_reg <= 1'b0;
            end
            if (ci_new) begin
                c_pend_reg <= 1'b1;
                c_word_reg <= {1'b1, 3'h0, CI.port, CI.chan, 2'h0, CI.prim};
                c_ts_reg   <= ts_cnt_reg;
            end else if (sel_ci_reg && MEM_ACK && (ovr_set || (state_reg == S_WR0
                         && !ts_en_reg) || state_reg == S_WR1)) begin
                c_pend_reg <= 1'b0;
            end
            if (TXS_VALID && !d_pend_reg) begin
                d_pend_reg <= 1'b1;
                d_addr_reg <= TXS.addr + DSTAT_OFS;
                d_word_reg <= {TXS.sent_ok, TXS.abort, TXS.underrun, 13'h0000};
            end else if (state_reg == S_DESC && MEM_ACK) begin
                d_pend_reg <= 1'b0;
            end
        end
    end

    always_comb begin
        HEV_BUSY = h_pend_reg;
        TXS_BUSY = d_pend_reg;
    end

    // Queue pointers with wrap
    assign h_step      = {1'b0, hq_ptr_reg} + 9'h001;
    assign c_step      = {1'b0, cq_ptr_reg} + (ts_en_reg ? 9'h002 : 9'h001);
    assign hq_ptr_next = (h_step >= {1'b0, qsize_reg[7:0]}) ? 8'h00 : h_step[7:0];
    assign cq_ptr_next = (c_step >= {1'b0, qsize_reg[15:8]}) ? 8'h00 : c_step[7:0];

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            hq_ptr_reg <= 8'h00;
            cq_ptr_reg <= 8'h00;
        end else if (CE && WR && ADDR == REG_QSIZE) begin
            hq_ptr_reg <= 8'h00;
            cq_ptr_reg <= 8'h00;
        end else if (CE && MEM_ACK && !sel_ci_reg && state_reg == S_WR0) begin
            hq_ptr_reg <= hq_ptr_next;
        end else if (CE && MEM_ACK && sel_ci_reg && (state_reg == S_WR1
                     || (state_reg == S_WR0 && !ts_en_reg))) begin
            cq_ptr_reg <= cq_ptr_next;
        end
    end

    // Memory sequencer: read the flag, then write the queue event; descriptor status is written without a read
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            state_reg  <= S_IDLE;
            sel_ci_reg <= 1'b0;
            MEM_REQ    <= 1'b0;
            MEM_WE     <= 1'b0;
            MEM_ADDR   <= RST_WORD[23:0];
            MEM_WDATA  <= 16'h0000;
        end else if (CE) begin
            unique case (state_reg)
                S_IDLE: begin
                    if (d_pend_reg) begin
                        MEM_REQ   <= 1'b1;
                        MEM_WE    <= 1'b1;
                        MEM_ADDR  <= d_addr_reg;
                        MEM_WDATA <= d_word_reg;
                        state_reg <= S_DESC;
                    end else if (h_pend_reg || c_pend_reg) begin
                        MEM_REQ    <= 1'b1;
                        MEM_WE     <= 1'b0;
                        sel_ci_reg <= !h_pend_reg;
                        MEM_ADDR   <= h_pend_reg
                                      ? hq_base_reg + {15'h0000, hq_ptr_reg, 1'b0}
                                      : cq_base_reg + {15'h0000, cq_ptr_reg, 1'b0};
                        state_reg  <= S_READ;
                    end
                end
                S_READ: begin
                    if (MEM_ACK) begin
                        if (MEM_RDATA[NS_BIT]) begin
                            MEM_REQ   <= 1'b0;
                            state_reg <= S_IDLE;
                        end else begin
                            MEM_WE    <= 1'b1;
                            MEM_WDATA <= sel_ci_reg ? c_word_reg : h_word_reg;
                            state_reg <= S_WR0;
                        end
                    end
                end
                S_WR0: begin
                    if (MEM_ACK) begin
                        if (sel_ci_reg && ts_en_reg) begin
                            MEM_ADDR  <= MEM_ADDR + WORD_BYTES;
                            MEM_WDATA <= c_ts_reg;
                            state_reg <= S_WR1;
                        end else begin
                            MEM_REQ   <= 1'b0;
                            MEM_WE    <= 1'b0;
                            state_reg <= S_IDLE;
                        end
                    end
                end
                S_WR1, S_DESC: begin
                    if (MEM_ACK) begin
                        MEM_REQ   <= 1'b0;
                        MEM_WE    <= 1'b0;
                        state_reg <= S_IDLE;
                    end
                end
            endcase
        end
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST || !CE);

    sequence busy_seen;
        state_reg == S_READ && MEM_ACK && MEM_RDATA[NS_BIT];
    endsequence

    sequence free_seen;
        state_reg == S_READ && MEM_ACK && !MEM_RDATA[NS_BIT];
    endsequence

    overrun_flag_a: assert property (busy_seen |=> ovr_reg ##1 IRQ)
        else $error("overrun not flagged");
    no_overwrite_a: assert property (busy_seen |=> !MEM_REQ && state_reg == S_IDLE)
        else $error("busy location touched");
    ns_write_a: assert property (free_seen |=> MEM_WE && MEM_WDATA[NS_BIT]
                                 && MEM_ADDR == $past(MEM_ADDR))
        else $error("event write lacks status flag");
    read_first_a: assert property ($rose(state_reg == S_WR0)
                                   |-> $past(state_reg) == S_READ)
        else $error("write without flag read");
    prio_class_a: assert property (TXC_VALID |=> TX_PRIO_CLASS
                                   == ($past(TXC.word1[PRI_BIT]) ? 4'h8 : 4'hA))
        else $error("wrong priority class");
    crc_corrupt_a: assert property (TXC_VALID |=> TX_CRC_CORRUPT
                                    == $past(TXC.word1[CRC_BIT]))
        else $error("crc corrupt not passed");
    desc_status_a: assert property (state_reg == S_DESC |-> MEM_WE
                                    && MEM_WDATA[12:0] == 13'h0000)
        else $error("bad descriptor status word");
    ts_second_a: assert property (state_reg == S_WR0 && MEM_ACK && sel_ci_reg
                                  && ts_en_reg |=> state_reg == S_WR1
                                  && MEM_WDATA == c_ts_reg)
        else $error("time stamp word missing");
    hdlc_word_a: assert property (state_reg == S_WR0 && !sel_ci_reg
                                  |-> MEM_WDATA[7:5] == 3'h0
                                  && MEM_WDATA[14] == 1'b0)
        else $error("reserved event bits set");
    ptr_wrap_a: assert property (qsize_reg[7:0] != 8'h00
                                 |-> hq_ptr_reg < qsize_reg[7:0])
        else $error("queue pointer past end");
endmodule : hdlc_event_queue_writer

// >>> tb/shared_mem_model.sv
`timescale 1ns/1ps
module shared_mem_model (
    // Clock and pacing
    input  wire logic        clk,
    input  wire logic        slow,
    // Memory port
    input  wire logic        req,
    input  wire logic        we,
    input  wire logic [23:0] addr,
    input  wire logic [15:0] wdata,
    output logic             ack = 1'b0,
    output logic      [15:0] rdata
);
    logic [15:0] mem [256];
    logic [15:0] rd_reg = 16'h0000;
    logic [1:0]  cnt_reg = 2'h0;

    initial begin
        foreach (mem[i]) mem[i] = 16'h0000;
    end

    // Outside the acknowledge cycle the bus shows the inverse of the last read
    assign rdata = ack ? rd_reg : ~rd_reg;

    // One acknowledge pulse per request, after 0 or 2 wait cycles
    always @(posedge clk) begin
        ack <= 1'b0;
        if (req && !ack) begin
            if (cnt_reg == (slow ? 2'h2 : 2'h0)) begin
                ack     <= 1'b1;
                cnt_reg <= 2'h0;
                if (we)
                    mem[addr[8:1]] <= wdata;
                else
                    rd_reg <= mem[addr[8:1]];
            end else begin
                cnt_reg <= cnt_reg + 2'h1;
            end
        end
    end
endmodule : shared_mem_model

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import hdlc_evq_pkg::*;
    logic        mclk = 1'b0, rst = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0, slow = 1'b0;
    logic        hev_valid = 1'b0, ci_valid = 1'b0, txs_valid = 1'b0, txc_valid = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata, d;
    hdlc_evt_t   hev = '0;
    ci_evt_t     ci = '0;
    txd_stat_t   txs = '0;
    txd_cfg_t    txc = '0;
    logic        irq, hev_busy, txs_busy, crc_c, len_err, mem_req, mem_we, mem_ack;
    logic [3:0]  prio;
    logic [23:0] last_addr, mem_addr;
    logic [15:0] mem_wdata, mem_rdata;
    hdlc_evt_t   ev [4];
    logic [12:0] cnts [3];
    int          n_mismatch = 0, num_checks = 0;

    always #2.5 mclk = ~mclk;

    hdlc_event_queue_writer hdlc_event_queue_writer_inst (
        .MCLK(mclk), .RST(rst), .CE(1'b1), .ADDR(addr), .WDATA(wdata), .WR(wr_stb),
        .RD(rd_stb), .RDATA(rdata), .IRQ(irq), .HEV_VALID(hev_valid), .HEV(hev),
        .HEV_BUSY(hev_busy), .CI_VALID(ci_valid), .CI(ci), .TXS_VALID(txs_valid),
        .TXS(txs), .TXS_BUSY(txs_busy), .TXC_VALID(txc_valid), .TXC(txc),
        .TX_CRC_CORRUPT(crc_c), .TX_PRIO_CLASS(prio), .TX_LAST_ADDR(last_addr),
        .TX_LEN_ERR(len_err), .MEM_REQ(mem_req), .MEM_WE(mem_we), .MEM_ADDR(mem_addr),
        .MEM_WDATA(mem_wdata), .MEM_ACK(mem_ack), .MEM_RDATA(mem_rdata)
    );

    shared_mem_model shared_mem_model_inst (
        .clk(mclk), .slow(slow), .req(mem_req), .we(mem_we), .addr(mem_addr),
        .wdata(mem_wdata), .ack(mem_ack), .rdata(mem_rdata)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_sim;
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        addr   <= a;
        wdata  <= v;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1;
        v = rdata;
    endtask : rd

    // Let the request start, then wait for all memory traffic to finish
    task automatic wait_idle;
        int i;
        repeat (3) @(posedge mclk);
        #1;
        for (i = 0; i < 200 && (mem_req || hev_busy || txs_busy); i++) begin
            @(posedge mclk);
            #1;
        end
        if (i == 200) begin
            n_mismatch++;
            end_sim();
        end
    endtask : wait_idle

    task automatic hev_send(input hdlc_evt_t e);
        @(posedge mclk);
        hev       <= e;
        hev_valid <= 1'b1;
        @(posedge mclk);
        hev_valid <= 1'b0;
        wait_idle();
    endtask : hev_send

    // Same primitive sampled twice in a row
    task automatic ci_send(input ci_evt_t c);
        @(posedge mclk);
        ci       <= c;
        ci_valid <= 1'b1;
        @(posedge mclk);
        ci_valid <= 1'b0;
        @(posedge mclk);
        ci_valid <= 1'b1;
        @(posedge mclk);
        ci_valid <= 1'b0;
        wait_idle();
    endtask : ci_send

    function automatic logic [15:0] m(input logic [23:0] a);
        return shared_mem_model_inst.mem[a[8:1]];
    endfunction : m

    function automatic logic [15:0] hword(input hdlc_evt_t e);
        return {2'h2, e.tx, e.chan, 3'h0, e.tx ? e.frame_ok & e.irq_en & e.eof : e.frame_ok,
                e.buf_done & e.irq_en & !(e.tx & e.eof), e.halt, e.queue_end_flag, e.flag0};
    endfunction : hword

    function automatic logic [15:0] cword(input ci_evt_t c);
        return {4'h8, c.port, c.chan, 2'h0, c.prim};
    endfunction : cword

    initial begin
        ev   = '{{1'b1, 5'h1F, 7'h7B}, {1'b0, 5'h05, 7'h6D}, {1'b1, 5'h0C, 7'h68},
                 {1'b1, 5'h00, 7'h5E}};
        cnts = '{13'h0007, 13'h1000, 13'h1001};
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        #1;
        chk(prio, PRIO_LO);
        rd(REG_QSIZE, d);
        chk(d, 32'h0000_1010);
        rd(8'hFC, d);
        chk(d, 32'h0000_0000);
        for (int i = 0; i < 3; i++) begin
            @(posedge mclk);
            txc       <= {24'h00_1000, cnts[i], (i == 0) ? 16'h0200 : 16'h0100};
            txc_valid <= 1'b1;
            @(posedge mclk);
            txc_valid <= 1'b0;
            #1;
            chk(crc_c, i == 0);
            chk(prio, (i == 0) ? PRIO_LO : PRIO_HI);
            chk(len_err, cnts[i] > MAX_BYTES);
            if (i < 2)
                chk(last_addr, 24'h00_1000 + cnts[i] - (cnts[i][0] ? 1 : 2));
        end
        wr(REG_QSIZE, 32'h0000_0403);
        wr(REG_HQBASE, 32'h0000_0100);
        wr(REG_CQBASE, 32'h0000_0040);
        for (int i = 0; i < 3; i++) begin
            @(posedge mclk);
            txs       <= {24'h00_0020, 3'b100 >> i};
            txs_valid <= 1'b1;
            @(posedge mclk);
            txs_valid <= 1'b0;
            wait_idle();
            chk(m(24'h00_002A), {3'b100 >> i, 13'h0000});
        end
        for (int i = 0; i < 3; i++) begin
            hev_send(ev[i]);
            chk(m(24'h00_0100 + 2 * i), hword(ev[i]));
        end
        hev_send(ev[3]);
        chk(m(24'h00_0100), hword(ev[0]));
        rd(REG_INTSUM, d);
        chk(d, 32'h0000_0001);
        chk(irq, 1'b1);
        wr(REG_INTSUM, 32'h0000_0001);
        rd(REG_INTSUM, d);
        chk(d, 32'h0000_0000);
        // Software acknowledges the entry it has read
        shared_mem_model_inst.mem[8'h80] = m(24'h00_0100) & 16'h7FFF;
        slow <= 1'b1;
        ci_send({1'b1, 3'h6, 6'h2D});
        chk(m(24'h00_0040), cword({1'b1, 3'h6, 6'h2D}));
        wr(REG_GCFG, 32'h0000_0001);
        ci_send({1'b0, 3'h3, 6'h15});
        chk(m(24'h00_0042), cword({1'b0, 3'h3, 6'h15}));
        chk(m(24'h00_0044) != 16'h0000, 1'b1);
        end_sim();
    end
endmodule : tb_top
